// [rtl/bcp_top.sv]
/*
  bcp_top: supply selection, discharge sinks, charge sequencing, battery
  detection and safety timers of a single-cell charger.
  assumes: the analog loops and comparators sit outside; register writes
  arrive on a simple write strobe at the documented register offset.
*/
// Contract
// - pick adapter, then usb, then battery
// - dead or absent battery: valid above 4.3 V
// - shorted battery: adapter under 4.1 V moves to usb
// - dead battery: adapter kept once selected
// - good battery: 190 mV present, 125 mV absent
// - battery feeds system otherwise or when blocked
// - sink on the input that is absent
// - sink bits 11b force both sinks off
// - short test before charging starts
// - pre-charge, fast charge, then constant voltage
// - termination sets termination flag
// - no termination while limit loops active
// - half-rate timer when current reduced
// - charger off below selectable termination threshold
// - termination on at reset; off skips detection
// - recharge threshold starts detection sink test
// - removal then source test for insertion
// - rise then sink test, repeat until found
// - removal raises battery temperature error flag
// - separate pre and fast timers, enable bit
// - timers off while termination disabled
// - half-rate on after reset, bit clears it
// - rising supply, reset bit, recharge clear faults
module bcp_top #(
  parameter int unsigned DET_CYCLES = bcp_pkg::DET_CYCLES,
  parameter int unsigned TICK_CYCLES = bcp_pkg::TMR_TICK_CYCLES
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire bcp_pkg::bcp_comp_t comp_in,
  input wire bcp_pkg::bcp_ctrl_t ctrl,
  input wire logic reg_wr,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  output bcp_pkg::bcp_src_t sys_source,
  output logic ac_sink_en,
  output logic usb_sink_en,
  output logic charge_on,
  output logic precharge_current,
  output logic detection_sink_current,
  output logic termination_flag,
  output logic battery_temp_error,
  output logic precharge_timeout_flag,
  output logic fast_charge_timeout_flag,
  output logic timer_half_rate
);

  // refuse counts the counters cannot serve, at elaboration
  if (DET_CYCLES < 1 || TICK_CYCLES < 2) begin : g_bad_counts
    $error("bcp_top: detection and tick counts must be at least 1 and 2");
  end

  bcp_pkg::bcp_comp_t cs;
  logic [7:0] power_path_control_reg;
  bcp_pkg::bcp_src_t src_reg;
  bcp_pkg::bcp_src_t src_next;
  bcp_pkg::bcp_chg_state_t st_reg;
  bcp_pkg::bcp_chg_state_t st_next;
  logic ac_ok;
  logic usb_ok;
  logic ac_ok_d_reg;
  logic usb_ok_d_reg;
  logic supply_rise;
  logic ac_latched_reg;
  logic [31:0] det_cnt_reg;
  logic det_done;
  logic [31:0] tick_cnt_reg;
  logic tick;
  logic [15:0] tmr_reg;
  logic loops_active;
  logic timers_on;
  logic restart;

  // comparator results are asynchronous to ref_clk
  bcp_sync #(.WIDTH(bcp_pkg::COMP_W)) u_sync (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .async_in(comp_in),
    .sync_out(cs)
  );

  // input validity depends on the battery case
  always_comb begin
    if (cs.bat_above_uvlo) begin
      // hysteresis is done by the two comparators plus held state
      ac_ok = cs.ac_above_bat_hi || (ac_ok_d_reg && cs.ac_above_bat_lo);
      usb_ok = cs.usb_above_bat_hi || (usb_ok_d_reg && cs.usb_above_bat_lo);
    end else begin
      ac_ok = cs.ac_above_uvlo_rise || ac_ok_d_reg;
      usb_ok = cs.usb_above_uvlo_rise || usb_ok_d_reg;
      // shorted battery drops the adapter below the fixed threshold
      if (!cs.ac_above_fixed && !(cs.bat_above_short && ac_latched_reg)) begin
        ac_ok = 1'b0;
      end
    end
  end

  // previous validity for hysteresis and rising-edge detection
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      ac_ok_d_reg <= 1'b0;
      usb_ok_d_reg <= 1'b0;
    end else begin
      ac_ok_d_reg <= ac_ok;
      usb_ok_d_reg <= usb_ok;
    end
  end

  assign supply_rise = (ac_ok && !ac_ok_d_reg) || (usb_ok && !usb_ok_d_reg);

  // adapter priority, then usb, then battery
  always_comb begin
    if (ctrl.path_off) begin
      src_next = bcp_pkg::SRC_BAT;
    end else if (ac_ok) begin
      src_next = bcp_pkg::SRC_AC;
    end else if (usb_ok) begin
      src_next = bcp_pkg::SRC_USB;
    end else begin
      src_next = bcp_pkg::SRC_BAT;
    end
  end

  // dead battery keeps adapter once chosen
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      src_reg <= bcp_pkg::SRC_BAT;
      ac_latched_reg <= 1'b0;
    end else begin
      src_reg <= src_next;
      if (!ac_ok) begin
        ac_latched_reg <= 1'b0;
      end else if (src_next == bcp_pkg::SRC_AC) begin
        ac_latched_reg <= 1'b1;
      end
    end
  end

  assign sys_source = src_reg;

  // power path register on its documented offset
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      power_path_control_reg <= bcp_pkg::POWER_PATH_CONTROL_RESET;
    end else if (reg_wr && reg_addr == bcp_pkg::POWER_PATH_CONTROL_OFFSET) begin
      power_path_control_reg <= reg_wdata;
    end
  end

  // reads of any other offset return zero
  always_comb begin
    if (reg_addr == bcp_pkg::POWER_PATH_CONTROL_OFFSET) begin
      reg_rdata = power_path_control_reg;
    end else begin
      reg_rdata = 8'h00;
    end
  end

  // sinks pull down the absent input; mixed codes honoured per bit
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      ac_sink_en <= 1'b0;
      usb_sink_en <= 1'b0;
    end else begin
      ac_sink_en <= usb_ok && !ac_ok
        && !power_path_control_reg[bcp_pkg::POWER_PATH_CONTROL_ADSINK_BIT];
      usb_sink_en <= ac_ok && !usb_ok
        && !power_path_control_reg[bcp_pkg::POWER_PATH_CONTROL_USB_SINK_DISABLE_BIT];
    end
  end

  // detection time counter, restarted on every state change
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      det_cnt_reg <= '0;
    end else if (st_next != st_reg) begin
      det_cnt_reg <= '0;
    end else if (!det_done) begin
      det_cnt_reg <= det_cnt_reg + 32'h1;
    end
  end

  assign det_done = det_cnt_reg >= DET_CYCLES - 1;

  assign loops_active = cs.input_limit_loop || cs.thermal_loop;
  assign timers_on = ctrl.safety_timer_enable && ctrl.termination_enable;
  assign timer_half_rate = ctrl.dynamic_timer_enable
    && (loops_active || src_reg == bcp_pkg::SRC_BAT);
  assign restart = supply_rise || ctrl.charger_reset;

  // timer prescaler; half rate needs twice the cycles per tick
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      tick_cnt_reg <= '0;
    end else if (tick || st_next != st_reg) begin
      tick_cnt_reg <= '0;
    end else begin
      tick_cnt_reg <= tick_cnt_reg + 32'h1;
    end
  end

  assign tick = timer_half_rate ? (tick_cnt_reg >= 2 * TICK_CYCLES - 1)
    : (tick_cnt_reg >= TICK_CYCLES - 1);

  // phase timer counts ticks within pre-charge or fast charge
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      tmr_reg <= '0;
    end else if (st_next != st_reg) begin
      tmr_reg <= '0;
    end else if (tick && timers_on) begin
      tmr_reg <= tmr_reg + 16'h1;
    end
  end

  // charge sequencer
  always_comb begin
    st_next = st_reg;
    case (st_reg)
      bcp_pkg::CHG_IDLE: begin
        if (ctrl.charger_enable && src_reg != bcp_pkg::SRC_BAT) begin
          st_next = bcp_pkg::CHG_SHORT_TEST;
        end
      end
      bcp_pkg::CHG_SHORT_TEST: begin
        if (cs.bat_above_sc) begin
          st_next = bcp_pkg::CHG_PRE;
        end
      end
      bcp_pkg::CHG_PRE: begin
        if (cs.bat_above_lowv) begin
          st_next = bcp_pkg::CHG_FAST;
        end else if (timers_on && tmr_reg >= ctrl.precharge_ticks) begin
          st_next = bcp_pkg::CHG_FAULT;
        end
      end
      bcp_pkg::CHG_FAST: begin
        if (cs.bat_at_oreg) begin
          st_next = bcp_pkg::CHG_CV;
        end else if (timers_on && tmr_reg >= ctrl.fast_charge_ticks) begin
          st_next = bcp_pkg::CHG_FAULT;
        end
      end
      bcp_pkg::CHG_CV: begin
        if (ctrl.termination_enable && cs.i_below_term && !loops_active) begin
          st_next = bcp_pkg::CHG_DONE;
        end else if (timers_on && tmr_reg >= ctrl.fast_charge_ticks) begin
          st_next = bcp_pkg::CHG_FAULT;
        end
      end
      bcp_pkg::CHG_DONE: begin
        if (!cs.bat_above_rch && ctrl.termination_enable) begin
          st_next = bcp_pkg::CHG_DET_SINK;
        end
      end
      bcp_pkg::CHG_DET_SINK: begin
        if (!cs.bat_above_lowv) begin
          st_next = bcp_pkg::CHG_DET_SRC;
        end else if (det_done) begin
          st_next = ctrl.charger_enable ? bcp_pkg::CHG_PRE : bcp_pkg::CHG_IDLE;
        end
      end
      bcp_pkg::CHG_DET_SRC: begin
        if (cs.bat_above_rch) begin
          st_next = bcp_pkg::CHG_DET_SINK2;
        end else if (det_done) begin
          st_next = bcp_pkg::CHG_PRE;
        end
      end
      bcp_pkg::CHG_DET_SINK2: begin
        if (!cs.bat_above_lowv) begin
          st_next = bcp_pkg::CHG_DET_SRC;
        end else if (det_done) begin
          st_next = bcp_pkg::CHG_PRE;
        end
      end
      bcp_pkg::CHG_FAULT: begin
        if (restart || !cs.bat_above_rch) begin
          st_next = bcp_pkg::CHG_IDLE;
        end
      end
      default: begin
        st_next = bcp_pkg::CHG_IDLE;
      end
    endcase
    // disable wins everywhere; reset bit restarts a cycle
    if (!ctrl.charger_enable) begin
      st_next = bcp_pkg::CHG_IDLE;
    end else if (restart && st_reg != bcp_pkg::CHG_FAULT) begin
      st_next = bcp_pkg::CHG_IDLE;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_reg <= bcp_pkg::CHG_IDLE;
    end else begin
      st_reg <= st_next;
    end
  end

  // drive strobes and flags from the next state
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      charge_on <= 1'b0;
      precharge_current <= 1'b0;
      detection_sink_current <= 1'b0;
    end else begin
      charge_on <= st_next == bcp_pkg::CHG_FAST || st_next == bcp_pkg::CHG_CV;
      precharge_current <= st_next == bcp_pkg::CHG_PRE
        || st_next == bcp_pkg::CHG_DET_SRC
        || st_next == bcp_pkg::CHG_SHORT_TEST;
      detection_sink_current <= st_next == bcp_pkg::CHG_DET_SINK
        || st_next == bcp_pkg::CHG_DET_SINK2;
    end
  end

  // sticky status; set wins over clear in the same cycle
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      termination_flag <= 1'b0;
      battery_temp_error <= 1'b0;
      precharge_timeout_flag <= 1'b0;
      fast_charge_timeout_flag <= 1'b0;
    end else begin
      if (st_next == bcp_pkg::CHG_DONE && st_reg == bcp_pkg::CHG_CV) begin
        termination_flag <= 1'b1;
      end else if (st_next == bcp_pkg::CHG_PRE) begin
        termination_flag <= 1'b0;
      end
      if (st_next == bcp_pkg::CHG_DET_SRC) begin
        battery_temp_error <= 1'b1;
      end else if (st_next == bcp_pkg::CHG_PRE) begin
        battery_temp_error <= 1'b0;
      end
      if (st_reg == bcp_pkg::CHG_PRE && st_next == bcp_pkg::CHG_FAULT) begin
        precharge_timeout_flag <= 1'b1;
      end else if (st_reg == bcp_pkg::CHG_FAULT && st_next != st_reg) begin
        precharge_timeout_flag <= 1'b0;
      end
      if (st_reg != bcp_pkg::CHG_PRE && st_next == bcp_pkg::CHG_FAULT) begin
        fast_charge_timeout_flag <= 1'b1;
      end else if (st_reg == bcp_pkg::CHG_FAULT && st_next != st_reg) begin
        fast_charge_timeout_flag <= 1'b0;
      end
    end
  end

endmodule

// [pkg/bcp_pkg.sv]
/*
  bcp_pkg: constants, types and register layout for the battery charger
  and power path control block.
  assumes: a 100 MHz ref_clk; comparator results arrive asynchronously.
*/
package bcp_pkg;

  // clock rate and detection timing
  localparam int unsigned CLK_HZ = 100_000_000;
  localparam int unsigned DET_TIME_US = 500;
  localparam int unsigned DET_CYCLES = DET_TIME_US * (CLK_HZ / 1_000_000);

  // safety timer: one tick per this many cycles at full rate
  localparam int unsigned TMR_TICK_CYCLES = 100_000;

  // power_path_control register
  localparam logic [7:0] POWER_PATH_CONTROL_OFFSET = 8'h01;
  localparam logic [7:0] POWER_PATH_CONTROL_RESET = 8'h00;
  localparam int unsigned POWER_PATH_CONTROL_ADSINK_BIT = 1;
  localparam int unsigned POWER_PATH_CONTROL_USB_SINK_DISABLE_BIT = 0;

  // termination threshold select default: 7.5 percent
  localparam logic [1:0] TERM_SEL_RESET = 2'h2;

  // comparator inputs, all raw and asynchronous
  typedef struct packed {
    logic ac_above_uvlo_rise;  // ac above 4.3 V
    logic usb_above_uvlo_rise; // usb above 4.3 V
    logic ac_above_fixed;      // ac above 4.1 V
    logic ac_above_bat_hi;     // ac over battery by 190 mV
    logic ac_above_bat_lo;     // ac over battery by 125 mV
    logic usb_above_bat_hi;
    logic usb_above_bat_lo;
    logic bat_above_short;     // battery above 1.5 V
    logic bat_above_uvlo;      // battery good
    logic bat_above_sc;        // short_circuit_threshold
    logic bat_above_lowv;      // precharge_exit_threshold
    logic bat_above_rch;       // recharge_threshold
    logic bat_at_oreg;         // regulation_voltage reached
    logic i_below_term;        // current below termination level
    logic input_limit_loop;    // input-limit loop active
    logic thermal_loop;        // thermal loop active
  } bcp_comp_t;

  localparam int unsigned COMP_W = $bits(bcp_comp_t);

  // software controls
  typedef struct packed {
    logic charger_enable;
    logic termination_enable;
    logic safety_timer_enable;
    logic dynamic_timer_enable;
    logic charger_reset;       // one-cycle pulse
    logic path_off;            // power path blocked, e.g. off state
    logic [1:0] termination_threshold_sel;
    logic [15:0] precharge_ticks;
    logic [15:0] fast_charge_ticks;
  } bcp_ctrl_t;

  typedef enum logic [1:0] {
    SRC_BAT,
    SRC_AC,
    SRC_USB
  } bcp_src_t;

  typedef enum {
    CHG_IDLE,
    CHG_SHORT_TEST,
    CHG_PRE,
    CHG_FAST,
    CHG_CV,
    CHG_DONE,
    CHG_DET_SINK,
    CHG_DET_SRC,
    CHG_DET_SINK2,
    CHG_FAULT
  } bcp_chg_state_t;

endpackage

// [rtl/bcp_sync.sv]
/*
  bcp_sync: two-flop synchroniser for a bus of independent levels.
  assumes: each bit is a slow level; no bit relation is kept across bits.
*/
module bcp_sync #(
  parameter int unsigned WIDTH = 1
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta_reg;

  // first stage feeds only the second stage
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_reg <= '0;
      sync_out <= '0;
    end else begin
      meta_reg <= async_in;
      sync_out <= meta_reg;
    end
  end

endmodule

// [dv/bcp_top_assertions.sv]
/*
  bcp_chk: concurrent checks on the ports of bcp_top.
  assumes: bound into bcp_top below; counts are handed on by the bind.
*/
module bcp_chk #(
  parameter int unsigned DET_CYCLES = bcp_pkg::DET_CYCLES,
  parameter int unsigned TICK_CYCLES = bcp_pkg::TMR_TICK_CYCLES
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire bcp_pkg::bcp_comp_t comp_in,
  input wire bcp_pkg::bcp_ctrl_t ctrl,
  input wire logic reg_wr,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  input wire bcp_pkg::bcp_src_t sys_source,
  input wire logic ac_sink_en,
  input wire logic usb_sink_en,
  input wire logic charge_on,
  input wire logic precharge_current,
  input wire logic detection_sink_current,
  input wire logic termination_flag,
  input wire logic battery_temp_error,
  input wire logic precharge_timeout_flag,
  input wire logic fast_charge_timeout_flag,
  input wire logic timer_half_rate
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  int unsigned run_reg;
  // length of the running sink test, so its end can be judged
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) run_reg <= 0;
    else run_reg <= detection_sink_current ? run_reg + 1 : 0;
  end
  a_reg_write: assert property ((reg_wr && reg_addr == 8'h01) ##1 (reg_addr == 8'h01)
    |-> reg_rdata == $past(reg_wdata)) else $error("register write lost");
  a_unmapped_zero: assert property (reg_addr != 8'h01 |-> reg_rdata == 8'h00)
    else $error("unmapped read not zero");
  a_sinks_forced: assert property (reg_addr == 8'h01 && reg_rdata[1:0] == 2'b11
    |=> !ac_sink_en && !usb_sink_en) else $error("sink on while forced off");
  a_ac_first: assert property ((comp_in.bat_above_uvlo && comp_in.ac_above_bat_hi
    && !ctrl.path_off)[*5] |-> sys_source == bcp_pkg::SRC_AC) else $error("adapter not chosen");
  a_path_blocked: assert property (ctrl.path_off[*3] |-> sys_source == bcp_pkg::SRC_BAT)
    else $error("blocked path not on battery");
  a_term_held: assert property ((comp_in.input_limit_loop || comp_in.thermal_loop)[*4]
    |-> !$rose(termination_flag)) else $error("termination while loop active");
  a_half_off: assert property ((!ctrl.dynamic_timer_enable)[*2] |-> !timer_half_rate)
    else $error("half rate while disabled");
  a_fast_after_pre: assert property ($rose(charge_on) |-> $past(precharge_current))
    else $error("fast charge without pre-charge");
  a_timer_off: assert property (!(ctrl.safety_timer_enable && ctrl.termination_enable)[*2]
    |-> !$rose(precharge_timeout_flag) && !$rose(fast_charge_timeout_flag))
    else $error("timeout while timers off");
  // a removal, a disable or a reset bit legally cuts the sink test short
  a_sink_length: assert property ($fell(detection_sink_current) && !battery_temp_error
    && $past(ctrl.charger_enable) && !$past(ctrl.charger_reset)
    |-> run_reg >= DET_CYCLES && run_reg <= DET_CYCLES + 1) else $error("sink test length");
  a_fault_clear: assert property (ctrl.charger_reset
    |-> ##[1:3] !precharge_timeout_flag) else $error("fault not cleared");
  c_term: cover property ($rose(termination_flag));
  c_removal: cover property ($rose(battery_temp_error));
  c_timeout: cover property ($rose(precharge_timeout_flag));
endmodule

bind bcp_top bcp_chk #(.DET_CYCLES(DET_CYCLES), .TICK_CYCLES(TICK_CYCLES)) u_chk (.*);

// [dv/bcp_supply_model.sv]
/*
  bcp_supply_model: adapter, usb and battery seen through comparators.
  assumes: the bench sets voltages in mV just after a clock edge.
*/
module bcp_supply_model #(
  parameter int UVLO_MV = 3300,
  parameter int SC_MV = 1800,
  parameter int LOWV_MV = 3000,
  parameter int RCH_MV = 4100,
  parameter int OREG_MV = 4200
) (
  input var int ac_mv,
  input var int usb_mv,
  input var int bat_mv,
  input wire logic i_term,
  input wire logic ilim,
  input wire logic therm,
  output bcp_pkg::bcp_comp_t comp
);
  // comparator levels follow the voltages with no delay
  always_comb begin
    comp.ac_above_uvlo_rise = ac_mv > 4300;
    comp.usb_above_uvlo_rise = usb_mv > 4300;
    comp.ac_above_fixed = ac_mv > 4100;
    comp.ac_above_bat_hi = ac_mv > bat_mv + 190;
    comp.ac_above_bat_lo = ac_mv > bat_mv + 125;
    comp.usb_above_bat_hi = usb_mv > bat_mv + 190;
    comp.usb_above_bat_lo = usb_mv > bat_mv + 125;
    comp.bat_above_short = bat_mv > 1500;
    comp.bat_above_uvlo = bat_mv > UVLO_MV;
    comp.bat_above_sc = bat_mv > SC_MV;
    comp.bat_above_lowv = bat_mv > LOWV_MV;
    comp.bat_above_rch = bat_mv > RCH_MV;
    comp.bat_at_oreg = bat_mv >= OREG_MV;
    comp.i_below_term = i_term;
    comp.input_limit_loop = ilim;
    comp.thermal_loop = therm;
  end
endmodule

// [dv/test_battery_charger_power_path_ctrl.sv]
/*
  test_battery_charger_power_path_ctrl: self-checking bench for bcp_top.
  assumes: short counts (4 cycles) for detection time and timer tick.
*/
`define CHK(what, exp, got) begin checks++; if ((got) !== (exp)) begin fails++; \
  $display("[FAIL] %s exp %0h got %0h", what, exp, got); end end
module test_battery_charger_power_path_ctrl;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int DET = 4;
  logic ref_clk = 0, rst_n = 0, reg_wr = 0, ac_sink_en, usb_sink_en, charge_on;
  logic precharge_current, detection_sink_current, termination_flag, battery_temp_error;
  logic precharge_timeout_flag, fast_charge_timeout_flag, timer_half_rate;
  logic i_term = 0, ilim = 0, therm = 0;
  logic [7:0] reg_addr = 8'h01, reg_wdata = 8'h00, reg_rdata;
  int ac_mv = 0, usb_mv = 0, bat_mv = 3800, fails = 0, checks = 0, cyc = 0, n;
  bcp_pkg::bcp_comp_t comp_in;
  bcp_pkg::bcp_ctrl_t ctrl = '{1'b0, 1'b1, 1'b0, 1'b1, 1'b0, 1'b0, 2'h2, 16'h0002, 16'h0002};
  bcp_pkg::bcp_src_t sys_source;
  bcp_supply_model sup_u (.ac_mv(ac_mv), .usb_mv(usb_mv), .bat_mv(bat_mv), .i_term(i_term),
    .ilim(ilim), .therm(therm), .comp(comp_in));
  bcp_top #(.DET_CYCLES(DET), .TICK_CYCLES(4)) dut_u (.*);
  always #5 ref_clk = ~ref_clk;
  // a hang ends the run through the same report
  always @(posedge ref_clk) if (++cyc > 20000) begin fails++; finish_test(); end
  task automatic step(int k);
    repeat (k) @(posedge ref_clk);
    #1;
  endtask
  task automatic wr(logic [7:0] a, logic [7:0] d);
    reg_addr = a; reg_wdata = d; reg_wr = 1;
    step(1);
    reg_wr = 0;
  endtask
  // bounded wait for a design flag to reach a level
  task automatic wait_for(ref logic f, input logic v);
    for (n = 0; n < 200 && f !== v; n++) step(1);
  endtask
  task automatic t_sinks();
    `CHK("reset power_path_control", 8'h00, reg_rdata)
    usb_mv = 5000; ac_mv = 0; step(8);
    `CHK("usb src", bcp_pkg::SRC_USB, sys_source)
    `CHK("ac sink", 1'b1, ac_sink_en)
    wr(8'h05, 8'hff); step(1);
    `CHK("unmapped", 8'h00, reg_rdata)
    wr(8'h01, 8'h03); step(2);
    `CHK("power_path_control", 8'h03, reg_rdata)
    `CHK("sinks off", 2'b00, {ac_sink_en, usb_sink_en})
    wr(8'h01, 8'h00); usb_mv = 0; ac_mv = 5000; step(8);
    `CHK("usb sink", 1'b1, usb_sink_en)
  endtask
  task automatic t_source();
    usb_mv = 5000; step(8);
    `CHK("ac first", bcp_pkg::SRC_AC, sys_source)
    ac_mv = 3950; step(8);
    `CHK("hold band", bcp_pkg::SRC_AC, sys_source)
    ac_mv = 3900; step(8);
    `CHK("ac absent", bcp_pkg::SRC_USB, sys_source)
    ctrl.path_off = 1; step(8);
    `CHK("blocked", bcp_pkg::SRC_BAT, sys_source)
    ctrl.path_off = 0; usb_mv = 0; ac_mv = 0; step(8);
    `CHK("no input", bcp_pkg::SRC_BAT, sys_source)
    bat_mv = 1000; ac_mv = 5000; usb_mv = 5000; step(8);
    `CHK("short ac", bcp_pkg::SRC_AC, sys_source)
    ac_mv = 4000; step(8);
    `CHK("short usb", bcp_pkg::SRC_USB, sys_source)
    bat_mv = 2000; ac_mv = 5000; step(8); ac_mv = 4000; step(8);
    `CHK("dead keeps ac", bcp_pkg::SRC_AC, sys_source)
    usb_mv = 0; ac_mv = 5000; step(8);
  endtask
  task automatic to_done();
    bat_mv = 4200; i_term = 1; ilim = 1; step(10);
    `CHK("no term", 1'b0, termination_flag)
    ilim = 0; wait_for(termination_flag, 1'b1);
    `CHK("term flag", 1'b1, termination_flag)
    step(2);
    `CHK("charger off", 1'b0, charge_on)
  endtask
  task automatic t_charge();
    bat_mv = 2000; ctrl.charger_enable = 1; step(10);
    `CHK("pre", 2'b01, {charge_on, precharge_current})
    bat_mv = 3600; step(8);
    `CHK("fast", 1'b1, charge_on)
    to_done();
    i_term = 0; bat_mv = 4000; wait_for(detection_sink_current, 1'b1);
    for (n = 0; detection_sink_current === 1'b1 && n < 20; n++) step(1);
    `CHK("sink len", 1'b1, n >= DET && n <= DET + 1)
    `CHK("recharge", 1'b1, precharge_current)
    to_done();
    i_term = 0; bat_mv = 2500; wait_for(battery_temp_error, 1'b1);
    `CHK("removed", 1'b1, battery_temp_error)
    `CHK("insert test", 1'b1, precharge_current)
  endtask
  task automatic t_timer();
    bat_mv = 2000; ctrl.safety_timer_enable = 1; ilim = 1; step(3);
    `CHK("half rate", 1'b1, timer_half_rate)
    ctrl.dynamic_timer_enable = 0; step(3);
    `CHK("half off", 1'b0, timer_half_rate)
    wait_for(precharge_timeout_flag, 1'b1);
    `CHK("pre timeout", 1'b1, precharge_timeout_flag)
    `CHK("no fast timeout", 1'b0, fast_charge_timeout_flag)
    ctrl.termination_enable = 0; ctrl.charger_reset = 1; step(1);
    ctrl.charger_reset = 0; step(2);
    `CHK("cleared", 1'b0, precharge_timeout_flag)
    step(100);
    `CHK("timers off", 1'b0, precharge_timeout_flag)
  endtask
  task automatic finish_test();
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  initial begin
    step(4);
    rst_n = 1;
    step(2);
    t_sinks();
    t_source();
    t_charge();
    t_timer();
    finish_test();
  end
endmodule
